// ---- design/phy_base_regs.sv ----
`timescale 1ns/100ps
module phy_base_regs
#(
    parameter int LONG_RESET_CYCLES = phy_regs_pkg::LONG_RESET_CYC
)
(
    input wire logic clk,
    input wire logic sysRst,
    input wire logic hsel,
    input wire logic [phy_regs_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [phy_regs_pkg::DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [phy_regs_pkg::DATA_W-1:0] hrdata,
    output logic hresp,
    input wire logic linkPowerStatus,
    input wire logic contenderLinkOnIn,
    output logic contenderLinkOnOut,
    output logic contenderLinkOnOe,
    input wire logic [2:0] powerClassPins,
    input wire logic cablePowerSense,
    input wire logic resumeStart,
    input wire logic cfgTimeoutEvent,
    input wire logic stateTimeoutEvent,
    input wire logic resetOpportunity,
    input wire logic legacyNodePresent,
    output logic linkIfEnable,
    output logic selfIdLinkActive,
    output logic selfIdContender,
    output logic [2:0] selfIdPowerClass,
    output logic busResetActive,
    output logic busResetShort,
    output logic irq
);
    import phy_regs_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    function automatic logic isReg
    (
        input logic [7:0] addr,
        input logic [5:0] idx
    );
        isReg = (addr == {idx, 2'h0});
    endfunction

    logic addrPhase, hreadyout_ff, nxt_hreadyout;
    logic [DATA_W-1:0] hrdata_ff, nxt_hrdata, readWord;
    logic wrPend_ff, nxt_wrPend, rdPend_ff, nxt_rdPend;
    logic [7:0] wrAddr_ff, nxt_wrAddr, rdAddr_ff, nxt_rdAddr;
    logic wrNode, wrFlags, wrClear, wrEnable;
    logic linkActive_ff, nxt_linkActive, contender_ff, nxt_contender;
    logic [2:0] powerClass_ff, nxt_powerClass;
    logic resumeIe_ff, nxt_resumeIe, shortReq_ff, nxt_shortReq;
    logic cfgTo_ff, nxt_cfgTo, cablePwr_ff, nxt_cablePwr;
    logic stateTo_ff, nxt_stateTo, portEvt_ff, nxt_portEvt;
    logic cablePrev_ff, nxt_cablePrev, cableDrop, portSet;
    logic rstStart_ff, nxt_rstStart, rstShort_ff, nxt_rstShort, startNow;
    logic [EV_W-1:0] evtStatus_ff, nxt_evtStatus, evtEnable_ff, nxt_evtEnable;
    logic [EV_W-1:0] evtSrc, clrMask;
    logic linkOnReq, pinsLinkIf_ff, pinsSidLink_ff, pinsSidCont_ff;
    logic pinsLinkOn_ff, pinsBrActive_ff, pinsIrq_ff;
    logic [2:0] pinsSidPwr_ff;

    bus_reset_if brIf();

    bus_reset_timer
    #(
        .LONG_CYCLES(LONG_RESET_CYCLES)
    )
    u_timer
    (
        .clk(clk),
        .sysRst(sysRst),
        .br(brIf)
    );

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    // Reads take one wait state so a write just before is visible
    assign addrPhase = hsel && hready && htrans[1];

    always_comb
    begin
        nxt_wrPend = 1'b0;
        nxt_rdPend = 1'b0;
        nxt_wrAddr = wrAddr_ff;
        nxt_rdAddr = rdAddr_ff;
        nxt_hreadyout = 1'b1;
        nxt_hrdata = hrdata_ff;
        if (addrPhase)
        begin
            nxt_wrPend = hwrite;
            nxt_rdPend = !hwrite;
            nxt_wrAddr = haddr[7:0];
            nxt_rdAddr = haddr[7:0];
            nxt_hreadyout = hwrite;
        end
        if (rdPend_ff)
        begin
            nxt_hrdata = readWord;
        end
        if (sysRst)
        begin
            nxt_wrPend = 1'b0;
            nxt_rdPend = 1'b0;
            nxt_wrAddr = '0;
            nxt_rdAddr = '0;
            nxt_hreadyout = 1'b1;
            nxt_hrdata = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        wrPend_ff <= nxt_wrPend;
        rdPend_ff <= nxt_rdPend;
        wrAddr_ff <= nxt_wrAddr;
        rdAddr_ff <= nxt_rdAddr;
        hreadyout_ff <= nxt_hreadyout;
        hrdata_ff <= nxt_hrdata;
    end

    assign wrNode = wrPend_ff && isReg(wrAddr_ff, IDX_NODE);
    assign wrFlags = wrPend_ff && isReg(wrAddr_ff, IDX_FLAGS);
    assign wrClear = wrPend_ff && isReg(wrAddr_ff, IDX_EVT_CLEAR);
    assign wrEnable = wrPend_ff && isReg(wrAddr_ff, IDX_EVT_ENABLE);

    always_comb
    begin
        readWord = '0;
        if (isReg(rdAddr_ff, IDX_CAPS))
        begin
            readWord[SPEED_LSB +: 3] = SPEED_CODE;
            readWord[DELAY_LSB +: 4] = DELAY_CODE;
        end
        if (isReg(rdAddr_ff, IDX_NODE))
        begin
            readWord[LINK_ACTIVE_BIT] = linkActive_ff;
            readWord[CONTENDER_BIT] = contender_ff;
            readWord[JITTER_LSB +: 3] = JITTER_CODE;
            readWord[PWR_CLASS_LSB +: 3] = powerClass_ff;
        end
        if (isReg(rdAddr_ff, IDX_FLAGS))
        begin
            readWord[RESUME_IE_BIT] = resumeIe_ff;
            readWord[SHORT_RST_BIT] = shortReq_ff;
            readWord[CFG_TO_BIT] = cfgTo_ff;
            readWord[CABLE_PWR_BIT] = cablePwr_ff;
            readWord[STATE_TO_BIT] = stateTo_ff;
            readWord[PORT_EVT_BIT] = portEvt_ff;
        end
        if (isReg(rdAddr_ff, IDX_EVT_STATUS))
        begin
            readWord[EV_W-1:0] = evtStatus_ff;
        end
        if (isReg(rdAddr_ff, IDX_EVT_ENABLE))
        begin
            readWord[EV_W-1:0] = evtEnable_ff;
        end
        if (isReg(rdAddr_ff, IDX_SELF_ID))
        begin
            readWord[SID_LINK_BIT] = pinsSidLink_ff;
            readWord[SID_CONT_BIT] = pinsSidCont_ff;
            readWord[SID_PWR_LSB +: 3] = pinsSidPwr_ff;
        end
    end

    // ----------------------------------------
    // Base register fields
    // ----------------------------------------
    assign cableDrop = cablePrev_ff && !cablePowerSense;
    // resume sets port event only when enabled
    assign portSet = resumeStart && resumeIe_ff;

    always_comb
    begin
        nxt_linkActive = linkActive_ff;
        nxt_contender = contender_ff;
        nxt_powerClass = powerClass_ff;
        nxt_resumeIe = resumeIe_ff;
        nxt_shortReq = shortReq_ff;
        nxt_cablePrev = cablePowerSense;
        if (wrNode)
        begin
            nxt_linkActive = hwdata[LINK_ACTIVE_BIT];
            nxt_contender = hwdata[CONTENDER_BIT];
            nxt_powerClass = hwdata[PWR_CLASS_LSB +: 3];
        end
        // a bus reset start drops the request; a flags write in the same cycle wins
        if (startNow)
        begin
            nxt_shortReq = 1'b0;
        end
        if (wrFlags)
        begin
            nxt_resumeIe = hwdata[RESUME_IE_BIT];
            nxt_shortReq = hwdata[SHORT_RST_BIT];
        end
        nxt_cfgTo = (cfgTo_ff && !(wrFlags && hwdata[CFG_TO_BIT]))
            || cfgTimeoutEvent;
        nxt_cablePwr = (cablePwr_ff && !(wrFlags && hwdata[CABLE_PWR_BIT]))
            || cableDrop;
        nxt_stateTo = (stateTo_ff && !(wrFlags && hwdata[STATE_TO_BIT]))
            || stateTimeoutEvent;
        nxt_portEvt = (portEvt_ff && !(wrFlags && hwdata[PORT_EVT_BIT]))
            || portSet;
        if (sysRst)
        begin
            // link-active set on hardware reset only
            nxt_linkActive = LINK_ACTIVE_RST;
            nxt_contender = contenderLinkOnIn;
            // power class strap caught during reset
            nxt_powerClass = powerClassPins;
            nxt_resumeIe = RESUME_IE_RST;
            nxt_shortReq = FLAG_RST;
            nxt_cfgTo = FLAG_RST;
            nxt_cablePwr = CABLE_PWR_RST;
            nxt_stateTo = FLAG_RST;
            nxt_portEvt = FLAG_RST;
        end
    end

    always_ff @(posedge clk)
    begin
        linkActive_ff <= nxt_linkActive;
        contender_ff <= nxt_contender;
        powerClass_ff <= nxt_powerClass;
        resumeIe_ff <= nxt_resumeIe;
        shortReq_ff <= nxt_shortReq;
        cfgTo_ff <= nxt_cfgTo;
        cablePwr_ff <= nxt_cablePwr;
        stateTo_ff <= nxt_stateTo;
        portEvt_ff <= nxt_portEvt;
        cablePrev_ff <= nxt_cablePrev;
    end

    // ----------------------------------------
    // Bus reset launch
    // ----------------------------------------
    // A timeout during a running reset is not queued: it is moot
    // state timeout launches a bus reset
    // timeouts arrive from the arbitration logic
    assign startNow = !rstStart_ff && !brIf.active
        && (stateTimeoutEvent || (shortReq_ff && resetOpportunity));

    always_comb
    begin
        nxt_rstStart = startNow;
        nxt_rstShort = rstShort_ff;
        if (startNow)
        begin
            // legacy node turns short into long
            nxt_rstShort = !stateTimeoutEvent && !legacyNodePresent;
        end
        if (sysRst)
        begin
            nxt_rstStart = 1'b0;
            nxt_rstShort = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        rstStart_ff <= nxt_rstStart;
        rstShort_ff <= nxt_rstShort;
    end

    assign brIf.start = rstStart_ff;
    assign brIf.isShort = rstShort_ff;

    // ----------------------------------------
    // Event status and interrupt
    // ----------------------------------------
    always_comb
    begin
        evtSrc = '0;
        evtSrc[EV_CFG_TO] = cfgTimeoutEvent;
        evtSrc[EV_CABLE] = cableDrop;
        evtSrc[EV_STATE_TO] = stateTimeoutEvent;
        evtSrc[EV_PORT] = portSet;
        evtSrc[EV_BUS_RST] = brIf.done;
        clrMask = wrClear ? hwdata[EV_W-1:0] : '0;
        // a new event beats a clear
        nxt_evtStatus = (evtStatus_ff & ~clrMask) | evtSrc;
        nxt_evtEnable = wrEnable ? hwdata[EV_W-1:0] : evtEnable_ff;
        if (sysRst)
        begin
            nxt_evtStatus = '0;
            nxt_evtEnable = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        evtStatus_ff <= nxt_evtStatus;
        evtEnable_ff <= nxt_evtEnable;
    end

    // ----------------------------------------
    // Pins and self-ID bits
    // ----------------------------------------
    // port event wakes regardless of enable
    assign linkOnReq = !linkPowerStatus && (portEvt_ff
        || (resumeIe_ff && (cfgTo_ff || cablePwr_ff || stateTo_ff)));

    always_ff @(posedge clk)
    begin
        if (sysRst)
        begin
            pinsLinkIf_ff <= 1'b0;
            pinsSidLink_ff <= 1'b0;
            pinsSidCont_ff <= 1'b0;
            pinsSidPwr_ff <= '0;
            pinsLinkOn_ff <= 1'b0;
            pinsBrActive_ff <= 1'b0;
            pinsIrq_ff <= 1'b0;
        end
        else
        begin
            // link side follows power status only
            pinsLinkIf_ff <= linkPowerStatus;
            pinsSidLink_ff <= linkActive_ff && linkPowerStatus;
            pinsSidCont_ff <= contender_ff;
            pinsSidPwr_ff <= powerClass_ff;
            pinsLinkOn_ff <= linkOnReq;
            pinsBrActive_ff <= brIf.active;
            pinsIrq_ff <= |(evtStatus_ff & evtEnable_ff);
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hrdata = hrdata_ff;
    assign hresp = HRESP_OKAY;
    assign linkIfEnable = pinsLinkIf_ff;
    assign selfIdLinkActive = pinsSidLink_ff;
    assign selfIdContender = pinsSidCont_ff;
    assign selfIdPowerClass = pinsSidPwr_ff;
    // Pin is an input strap until a wakeup drives it high
    assign contenderLinkOnOut = pinsLinkOn_ff;
    assign contenderLinkOnOe = pinsLinkOn_ff;
    assign busResetActive = pinsBrActive_ff;
    assign busResetShort = rstShort_ff;
    assign irq = pinsIrq_ff;
endmodule

// ---- include/phy_regs_pkg.sv ----
package phy_regs_pkg;

    // ----------------------------------------
    // Bus
    // ----------------------------------------
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // ----------------------------------------
    // Register indices, byte address is 4x
    // ----------------------------------------
    localparam logic [5:0] IDX_CAPS = 6'h03;
    localparam logic [5:0] IDX_NODE = 6'h04;
    localparam logic [5:0] IDX_FLAGS = 6'h05;
    localparam logic [5:0] IDX_EVT_STATUS = 6'h10;
    localparam logic [5:0] IDX_EVT_CLEAR = 6'h11;
    localparam logic [5:0] IDX_EVT_ENABLE = 6'h12;
    localparam logic [5:0] IDX_SELF_ID = 6'h13;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int SPEED_LSB = 5;
    localparam int DELAY_LSB = 0;
    localparam int LINK_ACTIVE_BIT = 7;
    localparam int CONTENDER_BIT = 6;
    localparam int JITTER_LSB = 3;
    localparam int PWR_CLASS_LSB = 0;
    localparam int RESUME_IE_BIT = 7;
    localparam int SHORT_RST_BIT = 6;
    localparam int CFG_TO_BIT = 5;
    localparam int CABLE_PWR_BIT = 4;
    localparam int STATE_TO_BIT = 3;
    localparam int PORT_EVT_BIT = 2;
    localparam int SID_LINK_BIT = 9;
    localparam int SID_CONT_BIT = 20;
    localparam int SID_PWR_LSB = 21;

    // ----------------------------------------
    // Fixed codes and reset values
    // ----------------------------------------
    localparam logic [2:0] SPEED_CODE = 3'h2;
    localparam logic [3:0] DELAY_CODE = 4'h0;
    localparam logic [2:0] JITTER_CODE = 3'h0;
    localparam logic LINK_ACTIVE_RST = 1'h1;
    localparam logic RESUME_IE_RST = 1'h0;
    localparam logic CABLE_PWR_RST = 1'h1;
    localparam logic FLAG_RST = 1'h0;

    // ----------------------------------------
    // Event status bits
    // ----------------------------------------
    localparam int EV_CFG_TO = 0;
    localparam int EV_CABLE = 1;
    localparam int EV_STATE_TO = 2;
    localparam int EV_PORT = 3;
    localparam int EV_BUS_RST = 4;
    localparam int EV_W = 5;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    // Short reset 1.30 us
    localparam int SHORT_RESET_NS = 1300;
    localparam int LONG_RESET_US = 166;
    localparam int SHORT_RESET_CYC =
        (SHORT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LONG_RESET_CYC =
        (LONG_RESET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 16;

    typedef enum logic [1:0]
    {
        RS_IDLE = 2'h1,
        RS_RUN = 2'h2
    } rst_state_e;

endpackage

// ---- include/bus_reset_if.sv ----
`timescale 1ns/100ps
interface bus_reset_if;
    logic start;
    logic isShort;
    logic active;
    logic done;

    modport ctl
    (
        output start,
        output isShort,
        input active,
        input done
    );

    modport tmr
    (
        input start,
        input isShort,
        output active,
        output done
    );
endinterface

// ---- design/bus_reset_timer.sv ----
`timescale 1ns/100ps
module bus_reset_timer
#(
    parameter int LONG_CYCLES = phy_regs_pkg::LONG_RESET_CYC
)
(
    input wire logic clk,
    input wire logic sysRst,
    bus_reset_if.tmr br
);
    import phy_regs_pkg::*;

    localparam logic [RST_CNT_W-1:0] SHORT_CNT =
        RST_CNT_W'(SHORT_RESET_CYC);
    localparam logic [RST_CNT_W-1:0] LONG_CNT = RST_CNT_W'(LONG_CYCLES);

    rst_state_e state_ff;
    rst_state_e nxt_state;
    logic [RST_CNT_W-1:0] cnt_ff;
    logic [RST_CNT_W-1:0] nxt_cnt;
    logic done_ff;
    logic nxt_done;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_done = 1'b0;
        unique case (state_ff)
            RS_IDLE:
            begin
                if (br.start)
                begin
                    nxt_state = RS_RUN;
                    nxt_cnt = br.isShort ? SHORT_CNT : LONG_CNT;
                end
            end
            RS_RUN:
            begin
                if (cnt_ff == RST_CNT_W'(1))
                begin
                    nxt_state = RS_IDLE;
                    nxt_done = 1'b1;
                end
                else
                begin
                    nxt_cnt = cnt_ff - RST_CNT_W'(1);
                end
            end
            default:
            begin
                nxt_state = RS_IDLE;
            end
        endcase
        if (sysRst)
        begin
            nxt_state = RS_IDLE;
            nxt_cnt = '0;
            nxt_done = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        state_ff <= nxt_state;
        cnt_ff <= nxt_cnt;
        done_ff <= nxt_done;
    end

    assign br.active = (state_ff == RS_RUN);
    assign br.done = done_ff;
endmodule

// ---- bench/phy_regs_monitor.sv ----
`timescale 1ns/100ps
module phy_regs_monitor
import phy_regs_pkg::*;
#(
    parameter int LONG_RESET_CYCLES = LONG_RESET_CYC
)
(
    input wire logic clk,
    input wire logic sysRst,
    input wire logic linkPowerStatus,
    input wire logic contenderLinkOnIn,
    input wire logic contenderLinkOnOut,
    input wire logic contenderLinkOnOe,
    input wire logic [2:0] powerClassPins,
    input wire logic stateTimeoutEvent,
    input wire logic linkIfEnable,
    input wire logic selfIdLinkActive,
    input wire logic selfIdContender,
    input wire logic [2:0] selfIdPowerClass,
    input wire logic busResetActive,
    input wire logic busResetShort
);
    // ----------------------------------------
    // Bus reset length counter
    // ----------------------------------------
    logic [15:0] activeCnt_ff;
    logic [15:0] nxt_activeCnt;
    always_comb
    begin
        nxt_activeCnt = busResetActive ? activeCnt_ff + 16'h1 : 16'h0;
    end
    always_ff @(posedge clk)
    begin
        activeCnt_ff <= sysRst ? 16'h0 : nxt_activeCnt;
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sysRst);
    sequence s_resetDone;
        $fell(busResetActive);
    endsequence
    sequence s_resetLeft;
        $fell(sysRst);
    endsequence

    a_sid_link_gate: assert property (
        !linkPowerStatus |=> !selfIdLinkActive)
        else $error("self-id link bit set without link power");
    a_link_ctrl_reset: assert property (
        s_resetLeft |=> selfIdLinkActive == $past(linkPowerStatus))
        else $error("link-active control not one after reset");
    // Last edge inside reset wins, two edges back
    a_strap_load: assert property (
        s_resetLeft |=> selfIdContender == $past(contenderLinkOnIn, 2)
            && selfIdPowerClass == $past(powerClassPins, 2))
        else $error("strap values not loaded at reset");
    a_if_follows_power: assert property (
        !$past(sysRst) |-> linkIfEnable == $past(linkPowerStatus))
        else $error("link interface enable not from power status");
    a_wake_quiet: assert property (
        linkPowerStatus |=> !contenderLinkOnOut && !contenderLinkOnOe)
        else $error("link-on driven while link active");
    a_short_len: assert property (
        s_resetDone ##0 busResetShort
            |-> activeCnt_ff == 16'(SHORT_RESET_CYC))
        else $error("short bus reset length wrong");
    a_long_len: assert property (
        s_resetDone ##0 !busResetShort
            |-> activeCnt_ff == 16'(LONG_RESET_CYCLES))
        else $error("long bus reset length wrong");
    a_timeout_reset: assert property (
        stateTimeoutEvent && !busResetActive |-> ##[1:4] busResetActive)
        else $error("state timeout gave no bus reset");
endmodule

bind phy_base_regs phy_regs_monitor
    #(.LONG_RESET_CYCLES(LONG_RESET_CYCLES)) u_mon
(
    .clk(clk), .sysRst(sysRst), .linkPowerStatus(linkPowerStatus),
    .contenderLinkOnIn(contenderLinkOnIn),
    .contenderLinkOnOut(contenderLinkOnOut),
    .contenderLinkOnOe(contenderLinkOnOe),
    .powerClassPins(powerClassPins), .stateTimeoutEvent(stateTimeoutEvent),
    .linkIfEnable(linkIfEnable), .selfIdLinkActive(selfIdLinkActive),
    .selfIdContender(selfIdContender), .selfIdPowerClass(selfIdPowerClass),
    .busResetActive(busResetActive), .busResetShort(busResetShort)
);

// ---- bench/link_ctrl_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// Link controller power, woken by link-on
// ----------------------------------------
module link_ctrl_model
#(
    parameter int WAKE_CYCLES = 16
)
(
    input wire logic clk,
    input wire logic sysRst,
    input wire logic sleepReq,
    input wire logic linkOnPin,
    output logic linkPowerStatus
);
    int wakeCnt = 0;
    initial linkPowerStatus = 1'h1;
    // Slow power-up, so the request must stand
    always @(posedge clk)
    begin
        if (sysRst || sleepReq)
        begin
            linkPowerStatus <= sysRst;
            wakeCnt <= 0;
        end
        else if (!linkPowerStatus && linkOnPin)
        begin
            wakeCnt <= wakeCnt + 1;
            if (wakeCnt == WAKE_CYCLES - 1)
                linkPowerStatus <= 1'h1;
        end
        else
            wakeCnt <= 0;
    end
endmodule

// ---- bench/phy_base_register_fields_tb.sv ----
`timescale 1ns/100ps
module phy_base_register_fields_tb;
    import phy_regs_pkg::*;
    localparam logic [7:0] ADR_CAPS = {IDX_CAPS, 2'h0};
    localparam logic [7:0] ADR_NODE = {IDX_NODE, 2'h0};
    localparam logic [7:0] ADR_FLAGS = {IDX_FLAGS, 2'h0};
    localparam logic [7:0] ADR_EVST = {IDX_EVT_STATUS, 2'h0};
    localparam logic [7:0] ADR_EVCLR = {IDX_EVT_CLEAR, 2'h0};
    localparam logic [7:0] ADR_EVEN = {IDX_EVT_ENABLE, 2'h0};
    localparam logic [7:0] ADR_SID = {IDX_SELF_ID, 2'h0};
    logic clk = 1'h0;
    logic sysRst = 1'h1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [2:0] pcPins = 3'h5;
    logic [2:0] sidPwr;
    logic [3:0] evt = 4'h0;
    logic strap = 1'h1;
    logic cablePowerSense = 1'h1;
    logic legacy = 1'h0;
    logic sleepReq = 1'h0;
    logic hreadyout, hresp, pinLevel, linkOnOut, linkOnOe, linkUp;
    logic linkIfEnable, sidLink, sidCont, brActive, brShort, irq;
    int badCount = 0;
    int nChecks = 0;

    always #2 clk = ~clk;
    // Pin is pulled to the strap level when released
    assign pinLevel = linkOnOe ? linkOnOut : strap;

    phy_base_regs #(.LONG_RESET_CYCLES(500)) u_dut
    (
        .clk(clk), .sysRst(sysRst), .hsel(1'h1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .linkPowerStatus(linkUp), .contenderLinkOnIn(pinLevel),
        .contenderLinkOnOut(linkOnOut), .contenderLinkOnOe(linkOnOe),
        .powerClassPins(pcPins), .cablePowerSense(cablePowerSense),
        .resumeStart(evt[0]), .cfgTimeoutEvent(evt[1]),
        .stateTimeoutEvent(evt[2]), .resetOpportunity(evt[3]),
        .legacyNodePresent(legacy), .linkIfEnable(linkIfEnable),
        .selfIdLinkActive(sidLink), .selfIdContender(sidCont),
        .selfIdPowerClass(sidPwr), .busResetActive(brActive),
        .busResetShort(brShort), .irq(irq)
    );
    link_ctrl_model u_link
    (
        .clk(clk), .sysRst(sysRst), .sleepReq(sleepReq),
        .linkOnPin(pinLevel), .linkPowerStatus(linkUp)
    );

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            badCount++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic waitRdy;
        @(posedge clk);
        while (hreadyout !== 1'h1)
            @(posedge clk);
    endtask
    task automatic busAcc(input logic [7:0] a, input logic w,
                          input logic [31:0] d);
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        waitRdy();
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
    endtask
    task automatic busWr(input logic [7:0] a, input logic [31:0] d);
        busAcc(a, 1'h1, d);
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        busAcc(a, 1'h0, 32'h0);
        check(hrdata, exp);
        check(hresp, HRESP_OKAY);
    endtask
    task automatic pulse(input int k);
        evt[k] <= 1'h1;
        @(posedge clk);
        evt[k] <= 1'h0;
        @(posedge clk);
    endtask
    task automatic waitBr;
        while (brActive !== 1'h1)
            @(posedge clk);
        while (brActive !== 1'h0)
            @(posedge clk);
    endtask
    task automatic doReset(input logic s, input logic [2:0] pc);
        strap <= s;
        pcPins <= pc;
        sysRst <= 1'h1;
        repeat (12) @(posedge clk);
        sysRst <= 1'h0;
        @(posedge clk);
    endtask
    // Event kinds: 0 port event kept, 1 cfg, 2 state, 3 cable drop
    task automatic sleepWake(input int k);
        cablePowerSense <= 1'h1;
        sleepReq <= 1'h1;
        @(posedge clk);
        sleepReq <= 1'h0;
        if (k == 3)
            cablePowerSense <= 1'h0;
        else if (k > 0)
            pulse(k);
        repeat (4) @(posedge clk);
        check(linkOnOut, k == 0);
        check(linkOnOe, k == 0);
        busWr(ADR_FLAGS, 32'h80);
        while (linkOnOut !== 1'h1)
            @(posedge clk);
        check(linkIfEnable, 1'h0);
        while (linkUp !== 1'h1)
            @(posedge clk);
        repeat (3) @(posedge clk);
        check(linkOnOut, 1'h0);
        busWr(ADR_FLAGS, 32'h3c);
    endtask
    task automatic final_report;
        if (badCount == 0 && nChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        doReset(1'h1, 3'h5);
        rdChk(ADR_NODE, 32'hc5);
        rdChk(ADR_CAPS, 32'h40);
        rdChk(ADR_FLAGS, 32'h10);
        rdChk(ADR_SID, 32'h00b00200);
        busWr(ADR_CAPS, 32'hffffffff);
        rdChk(ADR_CAPS, 32'h40);
        busWr(ADR_NODE, 32'hff);
        rdChk(ADR_NODE, 32'hc7);
        busWr(ADR_NODE, 32'h05);
        busWr(8'h1c, 32'hffffffff);
        rdChk(ADR_SID, 32'h00a00000);
        check(linkIfEnable, 1'h1);
        busWr(ADR_FLAGS, 32'h80);
        rdChk(ADR_FLAGS, 32'h90);
        doReset(1'h0, 3'h2);
        rdChk(ADR_NODE, 32'h82);
        rdChk(ADR_FLAGS, 32'h10);
        rdChk(ADR_SID, 32'h00400200);
        busWr(ADR_FLAGS, 32'h0);
        rdChk(ADR_FLAGS, 32'h10);
        busWr(ADR_FLAGS, 32'h10);
        rdChk(ADR_FLAGS, 32'h0);
        cablePowerSense <= 1'h0;
        @(posedge clk);
        rdChk(ADR_FLAGS, 32'h10);
        cablePowerSense <= 1'h1;
        busWr(ADR_FLAGS, 32'h10);
        pulse(1);
        pulse(2);
        rdChk(ADR_FLAGS, 32'h28);
        waitBr();
        check(brShort, 1'h0);
        busWr(ADR_FLAGS, 32'h28);
        rdChk(ADR_FLAGS, 32'h0);
        rdChk(ADR_NODE, 32'h82);
        busWr(ADR_EVCLR, 32'h1f);
        busWr(ADR_EVEN, 32'h01);
        pulse(1);
        @(posedge clk);
        check(irq, 1'h1);
        busWr(ADR_EVEN, 32'h0);
        repeat (2) @(posedge clk);
        check(irq, 1'h0);
        rdChk(ADR_EVST, 32'h01);
        busWr(ADR_EVCLR, 32'h01);
        rdChk(ADR_EVST, 32'h0);
        busWr(ADR_FLAGS, 32'h20);
        // Event lands on the same edge as the clearing write
        fork
            busWr(ADR_FLAGS, 32'h20);
            begin
                @(posedge clk);
                evt[1] <= 1'h1;
                @(posedge clk);
                evt[1] <= 1'h0;
            end
        join
        rdChk(ADR_FLAGS, 32'h20);
        busWr(ADR_FLAGS, 32'h20);
        for (int l = 0; l < 2; l++)
        begin
            legacy <= l[0];
            busWr(ADR_FLAGS, 32'h40);
            rdChk(ADR_FLAGS, 32'h40);
            pulse(3);
            waitBr();
            check(brShort, !l[0]);
            rdChk(ADR_FLAGS, 32'h0);
        end
        pulse(0);
        rdChk(ADR_FLAGS, 32'h0);
        busWr(ADR_FLAGS, 32'h80);
        pulse(0);
        rdChk(ADR_FLAGS, 32'h84);
        busWr(ADR_FLAGS, 32'h0);
        for (int k = 0; k < 4; k++)
            sleepWake(k);
        final_report();
    end

    initial
    begin
        #200000;
        badCount++;
        final_report();
    end
endmodule
